// file: shared/lnbr_defs.vh
// constants for the antenna supply regulator serial control block
`ifndef LNBR_DEFS_VH
`define LNBR_DEFS_VH

// bit positions within a written or read byte
`define LNBR_BIT_BANK 7
`define LNBR_BIT_STATIC 6
`define LNBR_BIT_SPARE 5
`define LNBR_BIT_TONE 4
`define LNBR_BIT_BOOST 3
`define LNBR_BIT_HIGHV 2
`define LNBR_BIT_PWR 1
`define LNBR_BIT_OVLD 0
`define LNBR_BIT_HEAT 1

// reset value of both registers
`define LNBR_REG_RST 8'h00

// 7-bit slave address with strap low; strap sets bit 0
`define LNBR_ADDR_BASE 7'h08

// regulator target codes on vout_sel_o
`define LNBR_V13 2'h0
`define LNBR_V18 2'h1
`define LNBR_V14 2'h2
`define LNBR_V19 2'h3

// protection timing in 10 MHz clocks: 900 ms off, 20 ms retry; sized to the 24-bit timer
`define LNBR_TOFF_CYC 24'h89_5440
`define LNBR_TON_CYC 24'h03_0d40

`endif

// file: src/lnbr_i2c_ctrl.v
// serial slave, control registers and overload timing of the antenna supply regulator
`timescale 1ns/100ps
`include "lnbr_defs.vh"

// Behaviour
// - write transfer stores data byte in registers
// - bit 7 selects first or second register
// - select and boost bits pick 13/18/14/19V
// - tone gated by pin unless forced on
// - limit style bit: one static, zero dynamic
// - power enable zero turns both converters off
// - read address sends register byte, MSB first
// - master ack continues read, nack ends it
// - readback whole byte; flag bits ignore writes
// - overheat flag follows sensor, forces power off
// - overload flag set while protection triggered
// - supply low: ignore bus, registers held zero
// - supply good makes interface operative
// - power enable zero after reset, atomic update
// - address 0001000 or 0001001 from strap
// - all register bits zero at power-on
// - write is address, one data byte, acks; further data bytes are also acked and stored
// - dynamic: off 900ms, retry 20ms, flag
// - static: overload flag follows current clamp
module lnbr_i2c_ctrl #(
   parameter [23:0] TOFF_CYC = `LNBR_TOFF_CYC,
   parameter [23:0] TON_CYC = `LNBR_TON_CYC
) (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe_o,
   input wire addr_strap_i,
   input wire supply_good_i,
   input wire overcurrent_i,
   input wire overheat_i,
   input wire tone_gate_input_i,
   output wire converter_en_o,
   output wire linear_en_o,
   output wire [1:0] vout_sel_o,
   output wire tone_on_o,
   output wire static_limit_o
);

   // serial states
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_ACKA = 7'h04;
   localparam [6:0] S_WR = 7'h08;
   localparam [6:0] S_ACKW = 7'h10;
   localparam [6:0] S_RD = 7'h20;
   localparam [6:0] S_ACKR = 7'h40;

   // overload protection states
   localparam [2:0] O_RUN = 3'h1;
   localparam [2:0] O_OFF = 3'h2;
   localparam [2:0] O_RETRY = 3'h4;

   // two-flop synchronisers for every outside input
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   reg scl_prev_q;
   reg sda_prev_q;

   reg [6:0] st_q;
   reg [7:0] shift_q;
   reg [2:0] cnt_q;
   reg full_q;
   reg rw_q;
   reg mack_q;
   reg bank_rd_q;
   reg sda_oe_q;
   reg sda_q;

   reg [6:1] ctrl_q;
   reg olf_q;
   reg [2:0] ol_q;
   reg [23:0] tmr_q;

   reg conv_q;
   reg lin_q;
   reg [1:0] high_voltage_choice_q;
   reg tone_q;
   reg static_q;

   wire scl_s = sync2_q[0];
   wire sda_s = sync2_q[1];
   wire strap_s = sync2_q[2];
   wire pgood_s = sync2_q[3];
   wire oc_s = sync2_q[4];
   wire heat_s = sync2_q[5];
   wire gate_s = sync2_q[6];

   wire scl_rise = scl_s & ~scl_prev_q;
   wire scl_fall = ~scl_s & scl_prev_q;
   wire start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   wire [6:0] my_addr = `LNBR_ADDR_BASE | {6'h00, strap_s};

   // readback images of the two registers
   wire [7:0] reg1 = {1'b0, ctrl_q, olf_q};
   wire [7:0] reg2 = {1'b1, 5'h00, heat_s, 1'b0};

   // regulator target from select and boost bits
   function [1:0] volt_code;
      input high_v;
      input boost;
      begin
         case ({boost, high_v})
            2'b00: volt_code = `LNBR_V13;
            2'b01: volt_code = `LNBR_V18;
            2'b10: volt_code = `LNBR_V14;
            default: volt_code = `LNBR_V19;
         endcase
      end
   endfunction

   // synchronisers; first stage feeds only the second
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= 7'h03; // scl and sda reset to idle high: no false edge
         sync2_q <= 7'h03;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (ce_i) begin
         sync1_q <= {tone_gate_input_i, overheat_i, overcurrent_i, supply_good_i,
                     addr_strap_i, sda_i, scl_i};
         sync2_q <= sync1_q;
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // serial slave; data pin only changes while the clock is low
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= S_IDLE;
         shift_q <= 8'h00;
         cnt_q <= 3'h0;
         full_q <= 1'b0;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         bank_rd_q <= 1'b0;
         sda_oe_q <= 1'b0;
         sda_q <= 1'b0;
         ctrl_q <= 6'h00;
      end else if (ce_i) begin
         sda_q <= 1'b0;
         if (!pgood_s) begin
            // lockout: no answer, registers cleared
            st_q <= S_IDLE;
            sda_oe_q <= 1'b0;
            ctrl_q <= 6'h00;
            full_q <= 1'b0;
            cnt_q <= 3'h0;
         end else if (start_c) begin
            st_q <= S_ADDR;
            cnt_q <= 3'h0;
            full_q <= 1'b0;
            sda_oe_q <= 1'b0;
         end else if (stop_c) begin
            st_q <= S_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            case (st_q)
               S_IDLE: begin
                  sda_oe_q <= 1'b0;
               end
               S_ADDR, S_WR: begin
                  if (scl_rise && !full_q) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     if (cnt_q == 3'h7) begin
                        full_q <= 1'b1;
                     end else begin
                        cnt_q <= cnt_q + 3'h1;
                     end
                  end else if (scl_fall && full_q) begin
                     full_q <= 1'b0;
                     cnt_q <= 3'h0;
                     if (st_q == S_ADDR) begin
                        if (shift_q[7:1] == my_addr) begin
                           rw_q <= shift_q[0];
                           st_q <= S_ACKA;
                           sda_oe_q <= 1'b1;
                        end else begin
                           st_q <= S_IDLE;
                        end
                     end else begin
                        // whole byte lands at once, so enable never leads
                        if (!shift_q[`LNBR_BIT_BANK]) begin
                           ctrl_q <= shift_q[6:1];
                        end
                        st_q <= S_ACKW;
                        sda_oe_q <= 1'b1;
                     end
                  end
               end
               S_ACKA: begin
                  if (scl_fall) begin
                     if (rw_q) begin
                        st_q <= S_RD;
                        shift_q <= reg1;
                        sda_oe_q <= ~reg1[7];
                        bank_rd_q <= 1'b1;
                     end else begin
                        st_q <= S_WR;
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
               S_ACKW: begin
                  if (scl_fall) begin
                     st_q <= S_WR;
                     sda_oe_q <= 1'b0;
                  end
               end
               S_RD: begin
                  if (scl_fall) begin
                     if (cnt_q == 3'h7) begin
                        cnt_q <= 3'h0;
                        sda_oe_q <= 1'b0;
                        st_q <= S_ACKR;
                     end else begin
                        cnt_q <= cnt_q + 3'h1;
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_q <= ~shift_q[6];
                     end
                  end
               end
               S_ACKR: begin
                  if (scl_rise) begin
                     mack_q <= ~sda_s;
                  end else if (scl_fall) begin
                     if (mack_q) begin
                        // alternate between the two registers
                        st_q <= S_RD;
                        shift_q <= bank_rd_q ? reg2 : reg1;
                        sda_oe_q <= bank_rd_q ? ~reg2[7] : ~reg1[7];
                        bank_rd_q <= ~bank_rd_q;
                     end else begin
                        st_q <= S_IDLE;
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
               default: begin
                  st_q <= S_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // overload protection and its flag
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ol_q <= O_RUN;
         olf_q <= 1'b0;
         tmr_q <= 24'h00_0000;
      end else if (ce_i) begin
         if (!pgood_s || !ctrl_q[`LNBR_BIT_PWR]) begin
            ol_q <= O_RUN;
            olf_q <= 1'b0;
            tmr_q <= 24'h00_0000;
         end else if (ctrl_q[`LNBR_BIT_STATIC]) begin
            ol_q <= O_RUN;
            olf_q <= oc_s;
            tmr_q <= 24'h00_0000;
         end else begin
            case (ol_q)
               O_RUN: begin
                  if (oc_s) begin
                     ol_q <= O_OFF;
                     olf_q <= 1'b1;
                     tmr_q <= 24'h00_0000;
                  end
               end
               O_OFF: begin
                  if (tmr_q == TOFF_CYC - 24'h00_0001) begin
                     ol_q <= O_RETRY;
                     tmr_q <= 24'h00_0000;
                  end else begin
                     tmr_q <= tmr_q + 24'h00_0001;
                  end
               end
               O_RETRY: begin
                  if (oc_s) begin
                     ol_q <= O_OFF;
                     tmr_q <= 24'h00_0000;
                  end else if (tmr_q == TON_CYC - 24'h00_0001) begin
                     ol_q <= O_RUN;
                     olf_q <= 1'b0;
                     tmr_q <= 24'h00_0000;
                  end else begin
                     tmr_q <= tmr_q + 24'h00_0001;
                  end
               end
               default: begin
                  ol_q <= O_RUN;
                  tmr_q <= 24'h00_0000;
               end
            endcase
         end
      end
   end

   // registered controls towards the analog blocks
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_q <= 1'b0;
         lin_q <= 1'b0;
         high_voltage_choice_q <= `LNBR_V13;
         tone_q <= 1'b0;
         static_q <= 1'b0;
      end else if (ce_i) begin
         // overheat and the off phase both override the enable
         conv_q <= ctrl_q[`LNBR_BIT_PWR] & ~heat_s & ~ol_q[2'd1];
         lin_q <= ctrl_q[`LNBR_BIT_PWR] & ~heat_s & ~ol_q[2'd1];
         high_voltage_choice_q <= volt_code(ctrl_q[`LNBR_BIT_HIGHV], ctrl_q[`LNBR_BIT_BOOST]);
         tone_q <= ctrl_q[`LNBR_BIT_TONE] | gate_s;
         static_q <= ctrl_q[`LNBR_BIT_STATIC];
      end
   end

   assign sda_o = sda_q;
   assign sda_oe_o = sda_oe_q;
   assign converter_en_o = conv_q;
   assign linear_en_o = lin_q;
   assign vout_sel_o = high_voltage_choice_q;
   assign tone_on_o = tone_q;
   assign static_limit_o = static_q;

endmodule // lnbr_i2c_ctrl

// file: dv/lnbr_i2c_ctrl_props.sv
// assertion checker for the regulator serial control block
`timescale 1ns/100ps
module lnbr_i2c_ctrl_props (
   input wire clk_i,
   input wire rst_i,
   input wire scl_i,
   input wire sda_o,
   input wire sda_oe_o,
   input wire supply_good_i,
   input wire overcurrent_i,
   input wire overheat_i,
   input wire tone_gate_input_i,
   input wire converter_en_o,
   input wire linear_en_o,
   input wire [1:0] vout_sel_o,
   input wire tone_on_o,
   input wire static_limit_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // input lags cover two sync flops plus the output register
   open_drain_a: assert property (sda_o == 1'b0)
      else $error("data output driven high");
   both_blocks_a: assert property (converter_en_o == linear_en_o)
      else $error("converter and linear enables differ");
   heat_cutoff_a: assert property (overheat_i [*5] |-> !converter_en_o)
      else $error("enable high while overheated");
   supply_clear_a: assert property (!supply_good_i [*6] |-> !converter_en_o && !sda_oe_o)
      else $error("activity while supply low");
   tone_gate_a: assert property ((tone_gate_input_i && supply_good_i) [*5] |-> tone_on_o)
      else $error("tone off while gate pin high");
   data_stable_a: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line moved while clock high");
   reset_zero_a: assert property ($fell(rst_i) |-> !converter_en_o && vout_sel_o == 2'h0)
      else $error("outputs not zero after reset");
   overload_cut_a: assert property (
      (overcurrent_i && !static_limit_o) [*5] |-> ##[0:4] !converter_en_o)
      else $error("dynamic overload left output on");
endmodule // lnbr_i2c_ctrl_props
bind lnbr_i2c_ctrl lnbr_i2c_ctrl_props lnbr_i2c_ctrl_props_i (.clk_i(clk_i), .rst_i(rst_i),
   .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .supply_good_i(supply_good_i),
   .overcurrent_i(overcurrent_i), .overheat_i(overheat_i), .tone_gate_input_i(tone_gate_input_i),
   .converter_en_o(converter_en_o), .linear_en_o(linear_en_o), .vout_sel_o(vout_sel_o),
   .tone_on_o(tone_on_o), .static_limit_o(static_limit_o));

// file: dv/lnbr_host_model.sv
// serial bus master model standing in for the host controller
`timescale 1ns/100ps
module lnbr_host_model (
   input wire clk_i,
   input wire sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // open drain: released data floats to the pull-up; clock idles high between frames
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // data moves mid-low, sampled at end of high; 800 ns clock period
   task automatic bit_x(input logic b, output logic r);
      scl_o = 1'b0;
      hw(2);
      sda_low_o = !b;
      hw(2);
      scl_o = 1'b1;
      hw(4);
      r = sda_i;
   endtask
   // eight bits msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] v, input logic a, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) bit_x(v[i], r[i]);
      bit_x(a, k);
   endtask
   task automatic start;
      sda_low_o = 1'b1;
      hw(4);
   endtask
   task automatic stop;
      scl_o = 1'b0;
      hw(2);
      sda_low_o = 1'b1;
      hw(2);
      scl_o = 1'b1;
      hw(4);
      sda_low_o = 1'b0;
      hw(4);
   endtask
endmodule // lnbr_host_model

// file: dv/lnbr_i2c_ctrl_tb.sv
// self-checking bench for the regulator serial control block
`timescale 1ns/100ps
module lnbr_i2c_ctrl_tb;
   logic clk_i = 0, rst_i = 1, strap = 0, sg = 0, oc = 0, oh = 0, tg = 0, overload_flag = 0, k;
   logic [7:0] ctl = 0, d, r;
   wire scl, hlow, oe, sdo, cvt, lin, tone, stat;
   wire [1:0] high_voltage_choice;
   wire sda = !(hlow | oe);
   int n_errors = 0, checked = 0, seed;
   initial forever #50 clk_i = ~clk_i;
   lnbr_host_model lnbr_host_model_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(hlow));
   // short protection timers keep the run brief
   lnbr_i2c_ctrl #(.TOFF_CYC(24'h00_0032), .TON_CYC(24'h00_000a)) lnbr_i2c_ctrl_i (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
      .addr_strap_i(strap), .supply_good_i(sg), .overcurrent_i(oc), .overheat_i(oh),
      .tone_gate_input_i(tg), .converter_en_o(cvt), .linear_en_o(lin), .vout_sel_o(high_voltage_choice),
      .tone_on_o(tone), .static_limit_o(stat));
   task automatic end_of_test;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic hw(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         n_errors++;
      end
   endtask
   // model: flag bits and bank bit never stored; power off clears overload
   task automatic wr(input logic [6:0] a, input logic [7:0] v, input logic ea);
      lnbr_host_model_i.start;
      lnbr_host_model_i.xfer({a, 1'b0}, 1'b1, r, k);
      chk("address ack", {7'h0, ea}, {7'h0, !k});
      if (!k) begin
         lnbr_host_model_i.xfer(v, 1'b1, r, k);
         chk("data ack", 8'h00, {7'h0, k});
      end
      lnbr_host_model_i.stop;
      if (ea && !v[7]) ctl = v & 8'h7e;
      if (!ctl[1]) overload_flag = 0;
   endtask
   task automatic rd(input logic [6:0] a);
      lnbr_host_model_i.start;
      lnbr_host_model_i.xfer({a, 1'b1}, 1'b1, r, k);
      chk("read ack", 8'h00, {7'h0, k});
      lnbr_host_model_i.xfer(8'hff, 1'b0, r, k);
      chk("register one", {1'b0, ctl[6:1], overload_flag}, r);
      lnbr_host_model_i.xfer(8'hff, 1'b0, r, k);
      chk("register two", {6'h20, oh, 1'b0}, r);
      lnbr_host_model_i.xfer(8'hff, 1'b1, r, k);
      chk("register one again", {1'b0, ctl[6:1], overload_flag}, r);
      lnbr_host_model_i.stop;
   endtask
   // outputs after the input synchronisers settle
   task automatic outs;
      logic en;
      hw(5);
      en = ctl[1] & !oh & !(overload_flag & !ctl[6]) & sg;
      chk("enable", {6'h0, en, en}, {6'h0, lin, cvt});
      chk("data out", 8'h00, {7'h0, sdo});
      chk("target", {6'h0, ctl[3:2]}, {6'h0, high_voltage_choice});
      chk("tone", {7'h0, ctl[4] | tg}, {7'h0, tone});
      chk("limit", {7'h0, ctl[6]}, {7'h0, stat});
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      #9000000;
      n_errors++;
      end_of_test;
   end
   initial begin
      seed = $urandom(47);
      hw(2);
      rst_i = 0;
      wr(7'h08, 8'h02, 0);
      outs();
      sg = 1;
      hw(5);
      rd(7'h08);
      for (int i = 0; i < 16; i++) begin
         d = (i < 4) ? {4'h0, i[1:0], 2'b10} : 8'($urandom);
         tg = 1'($urandom);
         wr(7'h08, d, 1);
         outs();
         rd(7'h08);
      end
      strap = 1;
      tg = 0;
      hw(5);
      wr(7'h08, 8'h00, 0);
      wr(7'h09, 8'h02, 1);
      oh = 1;
      outs();
      rd(7'h09);
      oh = 0;
      oc = 1;
      overload_flag = 1;
      outs();
      rd(7'h09);
      oc = 0;
      hw(80);
      overload_flag = 0;
      outs();
      wr(7'h09, 8'h42, 1);
      oc = 1;
      overload_flag = 1;
      outs();
      rd(7'h09);
      oc = 0;
      overload_flag = 0;
      outs();
      sg = 0;
      ctl = 0;
      wr(7'h09, 8'h06, 0);
      outs();
      end_of_test;
   end
endmodule // lnbr_i2c_ctrl_tb
